/* sps_cfg.svh */
// Register offsets, field positions and reset values for phase sync block
// Assumes inclusion by bare name from package and design files
`ifndef SPS_CFG_SVH
`define SPS_CFG_SVH
`define SPS_OFS_TARGET 8'h21
`define SPS_OFS_LOCATION 8'h26
`define SPS_OFS_CONFIG 8'h2c
`define SPS_OFS_HOMING 8'h47
`define SPS_BIT_DIR_INV 1
`define SPS_BIT_SYNC_EN 19
`define SPS_BIT_SYNC_GRAN 20
`define SPS_BIT_FULL_STOP 21
`define SPS_RST_WORD 32'h0000_0000
`define SPS_ADDR_MIN 7'h08
`define SPS_ADDR_MAX 7'h78
`define SPS_ADDR_DEF 7'h55
`define SPS_STEP_UNIT 32'h0000_0100
`endif

/* sps_pkg.sv */
// Types shared by the phase sync block
// Assumes sps_cfg.svh is reachable on the include path
`include "sps_cfg.svh"
package sps_pkg;
  typedef enum logic [1:0] {
    SPS_W2_POS = 2'b00,
    SPS_W1_POS = 2'b01,
    SPS_W2_NEG = 2'b11,
    SPS_W1_NEG = 2'b10
  } sps_phase_t;
  typedef struct packed {
    logic w1_pos;
    logic w1_neg;
    logic w2_pos;
    logic w2_neg;
  } sps_drive_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } sps_req_t;
endpackage

/* sps_step_gen.sv */
// Quarter-step stepper: moves location toward target in 64-unit increments
// Assumes the parent freezes it while the bridge is released
`timescale 1ns/10ps
module sps_step_gen
  import sps_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Control
  input wire logic run,
  input wire logic [31:0] location,
  input wire logic [31:0] goal,
  // Step request
  output logic step_pulse,
  output logic step_up
);
  localparam logic [31:0] QSTEP = `SPS_STEP_UNIT >> 2;
  logic [31:0] diff;
  logic [31:0] mag;
  assign diff = goal - location;
  assign mag = diff[31] ? 32'h0000_0000 - diff : diff;
  // Quarter step every other cycle; off-grid goals stop short, never hunt
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      step_pulse <= 1'b0;
      step_up <= 1'b0;
    end else begin
      step_pulse <= run && (mag >= QSTEP) && !step_pulse;
      step_up <= !diff[31];
    end
  end
endmodule // sps_step_gen

/* sps_phase_sync.sv */
// Stepper location-to-phase synchronisation with strapped address decode
// Assumes a register port from an I2C slave front end, synchronous pins
`timescale 1ns/10ps
module sps_phase_sync
  import sps_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Register port
  input sps_req_t req,
  output logic [31:0] rdata,
  // Homing completion load of location
  input wire logic home_load,
  input wire logic [31:0] home_value,
  // Supply monitor comparators
  input wire logic supply_under_9v,
  input wire logic supply_over_38v,
  // Address straps
  input wire logic [6:0] addr_strap,
  output logic [6:0] bus_addr,
  // Bridge
  output sps_drive_t drive,
  output logic bridge_released_state
);
  // ==========================================================
  // Registers
  logic [31:0] target_setpoint_reg;
  logic [31:0] current_location_reg;
  logic [31:0] config_flags_reg;
  logic [31:0] homing_origin_target_reg;
  logic sync_enable_bit;
  logic sync_granularity_bit;
  logic full_step_stop_bit;
  logic direction_invert_bit;
  assign sync_enable_bit = config_flags_reg[`SPS_BIT_SYNC_EN];
  assign sync_granularity_bit = config_flags_reg[`SPS_BIT_SYNC_GRAN];
  assign full_step_stop_bit = config_flags_reg[`SPS_BIT_FULL_STOP];
  assign direction_invert_bit = config_flags_reg[`SPS_BIT_DIR_INV];

  // Merge written location with kept low bits
  function automatic logic [31:0] merge_loc(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic en, input logic gran);
    if (!en)
      merge_loc = new_v;
    else if (gran)
      merge_loc = {new_v[31:8], old_v[7:0]};
    else
      merge_loc = {new_v[31:10], old_v[9:0]};
  endfunction

  // Winding chosen by full-step count, the only stable positions
  function automatic sps_phase_t decode_phase(input logic [1:0] fs,
      input logic inv);
    case (fs)
      2'd0: decode_phase = SPS_W2_POS;
      2'd1: decode_phase = inv ? SPS_W1_NEG : SPS_W1_POS;
      2'd2: decode_phase = SPS_W2_NEG;
      2'd3: decode_phase = inv ? SPS_W1_POS : SPS_W1_NEG;
      default: decode_phase = SPS_W2_POS;
    endcase
  endfunction

  // ==========================================================
  // Supply fault
  logic fault;
  assign fault = supply_under_9v || supply_over_38v;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn)
      bridge_released_state <= 1'b1;
    else
      bridge_released_state <= fault;
  end

  // ==========================================================
  // Motion
  logic [31:0] goal;
  logic step_pulse;
  logic step_up;
  assign goal = full_step_stop_bit ?
      {target_setpoint_reg[31:8], 8'h00} : target_setpoint_reg;
  // Quarter-step motion toward goal; multiples of 256 end on full step
  sps_step_gen u_step (
    .mclk(mclk),
    .rstn(rstn),
    .run(!bridge_released_state),
    .location(current_location_reg),
    .goal(goal),
    .step_pulse(step_pulse),
    .step_up(step_up)
  );

  // ==========================================================
  // Register writes
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      target_setpoint_reg <= `SPS_RST_WORD;
      config_flags_reg <= `SPS_RST_WORD;
      homing_origin_target_reg <= `SPS_RST_WORD;
    end else if (req.wr) begin
      case (req.addr)
        `SPS_OFS_TARGET: target_setpoint_reg <= req.wdata;
        `SPS_OFS_CONFIG: config_flags_reg <= req.wdata;
        `SPS_OFS_HOMING: homing_origin_target_reg <= req.wdata;
        default: ;
      endcase
    end
  end

  logic [31:0] qstep;
  assign qstep = `SPS_STEP_UNIT >> 2;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn)
      current_location_reg <= `SPS_RST_WORD;
    else if (req.wr && req.addr == `SPS_OFS_LOCATION)
      current_location_reg <= merge_loc(current_location_reg, req.wdata,
          sync_enable_bit, sync_granularity_bit);
    else if (home_load)
      current_location_reg <= merge_loc(current_location_reg, home_value,
          sync_enable_bit, sync_granularity_bit);
    else if (step_pulse && !bridge_released_state)
      current_location_reg <= step_up ? current_location_reg + qstep :
          current_location_reg - qstep;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn)
      rdata <= `SPS_RST_WORD;
    else if (req.rd) begin
      case (req.addr)
        `SPS_OFS_TARGET: rdata <= target_setpoint_reg;
        `SPS_OFS_LOCATION: rdata <= current_location_reg;
        `SPS_OFS_CONFIG: rdata <= config_flags_reg;
        `SPS_OFS_HOMING: rdata <= homing_origin_target_reg;
        default: rdata <= `SPS_RST_WORD;
      endcase
    end
  end

  // ==========================================================
  // Winding drive
  sps_phase_t phase;
  logic [1:0] fs_index;
  logic at_full;
  // Sync ties phase to location bits; otherwise a free step counter
  logic [1:0] free_fs;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn)
      free_fs <= 2'd0;
    else if (step_pulse && !bridge_released_state &&
        current_location_reg[7:6] == (step_up ? 2'd3 : 2'd0))
      free_fs <= step_up ? free_fs + 2'd1 : free_fs - 2'd1;
  end
  assign fs_index = sync_enable_bit ? current_location_reg[9:8] : free_fs;
  assign at_full = current_location_reg[7:0] == 8'h00;
  assign phase = decode_phase(fs_index, direction_invert_bit);
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn)
      drive <= '0;
    else if (fault)
      drive <= '0;
    else begin
      drive.w2_pos <= phase == SPS_W2_POS;
      drive.w1_pos <= phase == SPS_W1_POS;
      drive.w2_neg <= phase == SPS_W2_NEG;
      drive.w1_neg <= phase == SPS_W1_NEG;
    end
  end

  // ==========================================================
  // Strapped address, resampled every cycle after reset release
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn)
      bus_addr <= `SPS_ADDR_DEF;
    else if (addr_strap < `SPS_ADDR_MIN || addr_strap > `SPS_ADDR_MAX)
      bus_addr <= `SPS_ADDR_DEF;
    else
      bus_addr <= addr_strap;
  end

  // ==========================================================
  // Assertions
  a_fault_release: assert property (@(posedge mclk) disable iff (!rstn)
    fault |=> drive == '0 && bridge_released_state)
    else $error("bridge not released on supply fault");
  a_addr_fallback: assert property (@(posedge mclk) disable iff (!rstn)
    (addr_strap < 7'h08 || addr_strap > 7'h78) |=> bus_addr == 7'h55)
    else $error("bad strap did not fall back");
  a_addr_pass: assert property (@(posedge mclk) disable iff (!rstn)
    (addr_strap >= 7'h08 && addr_strap <= 7'h78) |=>
      bus_addr == $past(addr_strap))
    else $error("strap address not taken");
  a_keep_low8: assert property (@(posedge mclk) disable iff (!rstn)
    (req.wr && req.addr == 8'h26 && sync_enable_bit && sync_granularity_bit)
      |=> current_location_reg[7:0] == $past(current_location_reg[7:0]))
    else $error("low byte not kept");
  a_keep_low10: assert property (@(posedge mclk) disable iff (!rstn)
    (req.wr && req.addr == 8'h26 && sync_enable_bit && !sync_granularity_bit)
      |=> current_location_reg[9:0] == $past(current_location_reg[9:0]))
    else $error("low ten bits not kept");
  a_full_write: assert property (@(posedge mclk) disable iff (!rstn)
    (req.wr && req.addr == 8'h26 && !sync_enable_bit)
      |=> current_location_reg == $past(req.wdata))
    else $error("location write not stored");
  a_goal_mask: assert property (@(posedge mclk) disable iff (!rstn)
    full_step_stop_bit |-> goal[7:0] == 8'h00)
    else $error("target low byte not masked");
  a_phase_sync: assert property (@(posedge mclk) disable iff (!rstn)
    (sync_enable_bit && !fault && at_full &&
     current_location_reg[9:8] == 2'd2) |=> drive.w2_neg)
    else $error("phase not locked to location");
  a_quarter_step: assert property (@(posedge mclk) disable iff (!rstn)
    (step_pulse && !bridge_released_state && !req.wr && !home_load) |=>
      (current_location_reg - $past(current_location_reg) == 32'h0000_0040 ||
       $past(current_location_reg) - current_location_reg == 32'h0000_0040))
    else $error("step is not a quarter step");
  a_invert_swap: assert property (@(posedge mclk) disable iff (!rstn)
    (sync_enable_bit && !fault && direction_invert_bit &&
     current_location_reg[9:8] == 2'd1) |=> drive.w1_neg)
    else $error("invert did not swap winding 1");
endmodule // sps_phase_sync

/* sps_motor_model.sv */
// Model of the two-phase motor behind the bridge outputs
// Assumes the one-hot winding drive of the phase sync block
`timescale 1ns/10ps
module sps_motor_model
  import sps_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Bridge
  input sps_drive_t drive,
  input wire logic released,
  // Status
  output logic [1:0] rotor,
  output logic order_ok
);
  // ==========================================
  // Rotor follows the energised winding
  logic [1:0] pos;
  always_comb begin
    pos = drive.w1_pos ? 2'd1 : drive.w2_neg ? 2'd2 :
          drive.w1_neg ? 2'd3 : 2'd0;
  end
  // Open bridge gives no torque, so the rotor stays put
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rotor <= 2'd0;
      order_ok <= 1'b1;
    end else if (!released && drive != 4'h0) begin
      rotor <= pos;
      if (pos != rotor && pos != rotor + 2'd1 && pos != rotor - 2'd1)
        order_ok <= 1'b0;
    end
  end
endmodule // sps_motor_model

/* tb_top.sv */
// Register-level tests of the phase sync block with a motor model
// Assumes the design's register strobe port and comparator inputs
`timescale 1ns/10ps
module tb_top import sps_pkg::*; ;
  // ==========================================
  // Signals and instances
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  sps_req_t req = '0;
  logic [31:0] rdata;
  logic home_load = 1'b0;
  logic [31:0] home_value = 32'h0000_0000;
  logic uv = 1'b1;
  logic ov = 1'b0;
  logic [6:0] strap = 7'h28;
  logic [6:0] bus_addr;
  sps_drive_t drive;
  logic rel;
  logic order_ok;
  logic [1:0] rotor;
  logic [6:0] st [4] = '{7'h07, 7'h08, 7'h78, 7'h79};
  logic [6:0] se [4] = '{7'h55, 7'h08, 7'h78, 7'h55};
  logic [3:0] de [8] = '{4'h2, 4'h8, 4'h1, 4'h4, 4'h2, 4'h4, 4'h1, 4'h8};
  int num_errors = 0;
  int check_count = 0;
  always #12.5 mclk = ~mclk;
  sps_phase_sync uut(.mclk(mclk), .rstn(rstn), .req(req), .rdata(rdata),
    .home_load(home_load), .home_value(home_value),
    .supply_under_9v(uv), .supply_over_38v(ov), .addr_strap(strap),
    .bus_addr(bus_addr), .drive(drive), .bridge_released_state(rel));
  sps_motor_model motor(.mclk(mclk), .rstn(rstn), .drive(drive),
    .released(rel), .rotor(rotor), .order_ok(order_ok));
  // ==========================================
  // Tasks
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge mclk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge mclk);
    req.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(negedge mclk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    @(negedge mclk);
    req.rd = 1'b0;
    @(negedge mclk);
    cmp(rdata, e);
  endtask
  task automatic stop_test;
    if (num_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ==========================================
  // Tests
  initial begin
    #1_000_000;
    num_errors++;
    stop_test();
  end
  initial begin
    repeat (16) @(negedge mclk);
    cmp(32'(bus_addr), 32'h0000_0055);
    cmp(32'(rel), 32'h0000_0001);
    rstn = 1'b1;
    repeat (2) @(negedge mclk);
    cmp(32'(bus_addr), 32'h0000_0028);
    for (int i = 0; i < 4; i++) begin
      strap = st[i];
      repeat (2) @(negedge mclk);
      cmp(32'(bus_addr), 32'(se[i]));
    end
    rd(8'h21, 32'h0000_0000);
    rd(8'h2c, 32'h0000_0000);
    wr(8'h30, 32'h1234_5678);
    rd(8'h30, 32'h0000_0000);
    wr(8'h47, 32'h0000_0b00);
    rd(8'h47, 32'h0000_0b00);
    wr(8'h26, 32'h0001_6a40);
    rd(8'h26, 32'h0001_6a40);
    wr(8'h2c, 32'h0018_0000);
    wr(8'h26, 32'h0000_0000);
    rd(8'h26, 32'h0000_0040);
    wr(8'h2c, 32'h0000_0000);
    wr(8'h26, 32'h0001_6a40);
    wr(8'h2c, 32'h0008_0000);
    wr(8'h26, 32'h0000_0000);
    rd(8'h26, 32'h0000_0240);
    home_value = 32'h0000_0400;
    home_load = 1'b1;
    @(negedge mclk);
    home_load = 1'b0;
    rd(8'h26, 32'h0000_0640);
    cmp(32'(drive), 32'h0000_0000);
    wr(8'h2c, 32'h0000_0000);
    wr(8'h26, 32'h0000_0000);
    // Fault held during setup so no step slips in between writes
    for (int i = 0; i < 8; i++) begin
      wr(8'h2c, 32'h0018_0000 | {30'h0, i > 3, 1'b0});
      wr(8'h21, 32'(i % 4) << 8);
      wr(8'h26, 32'(i % 4) << 8);
      uv = 1'b0;
      repeat (3) @(negedge mclk);
      cmp(32'(rel), 32'h0000_0000);
      cmp(32'(drive), 32'(de[i]));
      uv = 1'b1;
    end
    wr(8'h2c, 32'h0038_0000);
    wr(8'h26, 32'h0000_0000);
    wr(8'h21, 32'h0000_02a5);
    uv = 1'b0;
    // Eight quarter steps, one every other cycle
    repeat (40) @(negedge mclk);
    rd(8'h26, 32'h0000_0200);
    cmp(32'(drive), 32'h0000_0001);
    cmp(32'(order_ok), 32'h0000_0001);
    cmp(32'(rotor), 32'h0000_0002);
    // Sync off: phase follows the steps taken, not the location bits
    wr(8'h2c, 32'h0020_0000);
    wr(8'h26, 32'h0000_0000);
    repeat (40) @(negedge mclk);
    rd(8'h26, 32'h0000_0200);
    cmp(32'(drive), 32'h0000_0002);
    cmp(32'(rotor), 32'h0000_0000);
    cmp(32'(order_ok), 32'h0000_0001);
    ov = 1'b1;
    wr(8'h21, 32'h0000_0400);
    repeat (20) @(negedge mclk);
    cmp(32'(rel), 32'h0000_0001);
    cmp(32'(drive), 32'h0000_0000);
    rd(8'h26, 32'h0000_0200);
    stop_test();
  end
endmodule // tb_top
